/* plw_defs.svh */
// Offsets, field positions, reset values and timing counts of the program loop watchdog
`ifndef PLW_DEFS_SVH
`define PLW_DEFS_SVH

// ********************************************************
// Register map
// ********************************************************
`define PLW_SERVICE_KEY_ADDR   20'hFFFAB
`define PLW_SERVICE_KEY_VALUE  8'hAC
`define PLW_SERVICE_RST_OFF    8'h1A
`define PLW_SERVICE_RST_ON     8'h9A

// ********************************************************
// Option byte fields
// ********************************************************
`define PLW_OPT_ENABLE_BIT     4
`define PLW_OPT_PERIOD_MSB     3
`define PLW_OPT_PERIOD_LSB     1
`define PLW_OPT_STANDBY_BIT    0

// ********************************************************
// Reset cause register
// ********************************************************
`define PLW_RESET_CAUSE_REGISTER_WDT_BIT       4

// ********************************************************
// Period exponents for select codes 0 to 7
// ********************************************************
`define PLW_EXP_0              5'h06
`define PLW_EXP_1              5'h07
`define PLW_EXP_2              5'h08
`define PLW_EXP_3              5'h09
`define PLW_EXP_4              5'h0B
`define PLW_EXP_5              5'h0D
`define PLW_EXP_6              5'h0E
`define PLW_EXP_7              5'h10

`endif

/* plw_pkg.sv */
// Types shared by the program loop watchdog files
package plw_pkg;

    typedef enum logic [1:0] {
        PLW_STOPPED,
        PLW_COUNTING,
        PLW_PAUSED
    } plw_state_t;

    typedef enum logic [1:0] {
        PLW_CAUSE_NONE,
        PLW_CAUSE_OVERFLOW,
        PLW_CAUSE_BAD_KEY,
        PLW_CAUSE_BIT_ACCESS
    } plw_cause_t;

endpackage

/* plw_tick_sync.sv */
// Synchroniser and edge detector for the low-speed oscillator clock
`timescale 1ns/1ps
`include "plw_defs.svh"

module plw_tick_sync (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    // Low-speed clock pin
    input  wire logic i_slow_clk,
    // One-cycle enable per rising edge
    output logic      o_tick
);

    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // ********************************************************
    // Two-stage synchroniser, edge taken from the second stage only
    // ********************************************************
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
            o_tick   <= 1'b0;
        end else begin
            meta_reg <= i_slow_clk;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
            o_tick   <= sync_reg & ~last_reg;
        end
    end

endmodule

/* plw_watchdog.sv */
// Program loop watchdog: counter, service key register, reset and interval request
`timescale 1ns/1ps
`include "plw_defs.svh"

module plw_watchdog #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST_B,
    // Low-speed on-chip oscillator clock
    input  wire logic        I_SLOW_CLK,
    // Option byte
    input  wire logic [7:0]  I_OPTION_BYTE,
    // Standby mode indication
    input  wire logic        I_STANDBY,
    // Register access
    input  wire logic [19:0] I_ADDR,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    input  wire logic        I_BIT_ACCESS,
    input  wire logic [7:0]  I_WDATA,
    output logic [7:0]       O_RDATA,
    // Reset and interrupt
    output logic             O_WDT_RESET,
    output logic             O_WATCHDOG_INTERVAL_IRQ,
    output logic             O_WATCHDOG_RESET_FLAG
);

    // Longest period needs a 16-bit count
    if (CNT_W < 16) begin
        $error("CNT_W must be at least 16");
    end

    // One spare bit so 2^n still fits when n equals the counter width
    localparam int FULL_W = CNT_W + 1;

    // ********************************************************
    // Decode helpers
    // ********************************************************
    function automatic logic [4:0] period_exp(input logic [2:0] sel);
        case (sel)
            3'h0:    period_exp = `PLW_EXP_0;
            3'h1:    period_exp = `PLW_EXP_1;
            3'h2:    period_exp = `PLW_EXP_2;
            3'h3:    period_exp = `PLW_EXP_3;
            3'h4:    period_exp = `PLW_EXP_4;
            3'h5:    period_exp = `PLW_EXP_5;
            3'h6:    period_exp = `PLW_EXP_6;
            default: period_exp = `PLW_EXP_7;
        endcase
    endfunction

    function automatic logic [7:0] service_reset_value(input logic enable);
        service_reset_value = enable ? `PLW_SERVICE_RST_ON : `PLW_SERVICE_RST_OFF;
    endfunction

    // ********************************************************
    // Option byte capture
    // ********************************************************
    // Option byte is latched in a clocked process after release, never
    // under reset, so a strap level is sampled without an async path.
    logic                  opt_valid_reg;
    logic                  watchdog_enable_option_reg;
    logic [2:0]            overflow_period_select_reg;
    logic                  standby_run_option_reg;
    logic                  int_rst;

    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            opt_valid_reg              <= 1'b0;
            watchdog_enable_option_reg <= 1'b0;
            overflow_period_select_reg <= 3'h0;
            standby_run_option_reg     <= 1'b0;
        end else if (!opt_valid_reg) begin
            opt_valid_reg              <= 1'b1;
            watchdog_enable_option_reg <= I_OPTION_BYTE[`PLW_OPT_ENABLE_BIT];
            overflow_period_select_reg <= I_OPTION_BYTE[`PLW_OPT_PERIOD_MSB:`PLW_OPT_PERIOD_LSB];
            standby_run_option_reg     <= I_OPTION_BYTE[`PLW_OPT_STANDBY_BIT];
        end
    end

    // ********************************************************
    // Slow clock enable
    // ********************************************************
    logic slow_tick;

    plw_tick_sync u_tick_sync (
        .i_clk      (I_CLK),
        .i_rst_b    (I_RST_B),
        .i_slow_clk (I_SLOW_CLK),
        .o_tick     (slow_tick)
    );

    // ********************************************************
    // Period limits
    // ********************************************************
    logic [4:0]       exp_n;
    logic [CNT_W:0]   full_cnt;
    logic [CNT_W-1:0] overflow_cnt;
    logic [CNT_W-1:0] interval_cnt;

    always_comb begin
        exp_n        = period_exp(overflow_period_select_reg);
        full_cnt     = FULL_W'(1) << exp_n;
        overflow_cnt = CNT_W'(full_cnt - FULL_W'(1));
        interval_cnt = CNT_W'((full_cnt >> 1) + (full_cnt >> 2));
    end

    // ********************************************************
    // Service register access decode
    // ********************************************************
    logic hit;
    logic key_ok;
    logic key_bad;
    logic bit_hit;

    always_comb begin
        hit     = (I_ADDR == `PLW_SERVICE_KEY_ADDR);
        bit_hit = hit & (I_WR | I_RD) & I_BIT_ACCESS;
        key_ok  = hit & I_WR & ~I_BIT_ACCESS & (I_WDATA == `PLW_SERVICE_KEY_VALUE);
        key_bad = hit & I_WR & ~I_BIT_ACCESS & (I_WDATA != `PLW_SERVICE_KEY_VALUE);
    end

    // ********************************************************
    // Counter state machine
    // ********************************************************
    plw_pkg::plw_state_t state_reg;
    plw_pkg::plw_state_t state_next;
    logic [CNT_W-1:0]    count_reg;
    logic                overflow;

    always_comb begin
        // A key written in the overflow cycle still rescues the count
        overflow   = (state_reg == plw_pkg::PLW_COUNTING) & slow_tick & ~key_ok
                     & (count_reg == overflow_cnt);
        state_next = state_reg;
        case (state_reg)
            plw_pkg::PLW_STOPPED: begin
                if (opt_valid_reg && watchdog_enable_option_reg) begin
                    state_next = plw_pkg::PLW_COUNTING;
                end
            end
            plw_pkg::PLW_COUNTING: begin
                if (I_STANDBY && !standby_run_option_reg) begin
                    state_next = plw_pkg::PLW_PAUSED;
                end
            end
            plw_pkg::PLW_PAUSED: begin
                if (!I_STANDBY) begin
                    state_next = plw_pkg::PLW_COUNTING;
                end
            end
            default: state_next = plw_pkg::PLW_STOPPED;
        endcase
    end

    // Internal reset returns state, count, reset and interval request to their post-reset values
    assign int_rst = O_WDT_RESET;

    always_ff @(posedge I_CLK) begin
        if (!I_RST_B || int_rst) begin
            state_reg <= plw_pkg::PLW_STOPPED;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_B || int_rst) begin
            count_reg <= '0;
        end else if (state_reg == plw_pkg::PLW_PAUSED) begin
            count_reg <= '0;
        end else if (state_reg == plw_pkg::PLW_COUNTING && key_ok) begin
            count_reg <= '0;
        end else if (state_reg == plw_pkg::PLW_COUNTING && slow_tick) begin
            count_reg <= count_reg + CNT_W'(1);
        end
    end

    // ********************************************************
    // Reset, cause flag and interval request
    // ********************************************************
    // Key checks apply even when counting is disabled, as the register
    // always answers at its address.
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B || int_rst) begin
            O_WDT_RESET <= 1'b0;
        end else begin
            O_WDT_RESET <= overflow | bit_hit | key_bad;
        end
    end

    // Flag survives the internal reset; only the external reset clears it
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            O_WATCHDOG_RESET_FLAG <= 1'b0;
        end else if (O_WDT_RESET) begin
            O_WATCHDOG_RESET_FLAG <= 1'b1;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_B || int_rst) begin
            O_WATCHDOG_INTERVAL_IRQ <= 1'b0;
        end else begin
            O_WATCHDOG_INTERVAL_IRQ <= (state_reg == plw_pkg::PLW_COUNTING) & slow_tick & ~key_ok
                                       & (count_reg + CNT_W'(1) == interval_cnt);
        end
    end

    // ********************************************************
    // Read data
    // ********************************************************
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            O_RDATA <= 8'h00;
        end else if (hit && I_RD && !I_BIT_ACCESS) begin
            O_RDATA <= service_reset_value(watchdog_enable_option_reg);
        end else begin
            O_RDATA <= 8'h00;
        end
    end

endmodule

/* plw_watchdog_props.sv */
// Concurrent checks on the program loop watchdog ports
`timescale 1ns/1ps
`include "plw_defs.svh"

module plw_watchdog_props (
    // Clock and reset
    input wire logic        I_CLK,
    input wire logic        I_RST_B,
    // Inputs
    input wire logic        I_SLOW_CLK,
    input wire logic [19:0] I_ADDR,
    input wire logic        I_WR,
    input wire logic        I_RD,
    input wire logic        I_BIT_ACCESS,
    input wire logic [7:0]  I_WDATA,
    // Outputs
    input wire logic [7:0]  O_RDATA,
    input wire logic        O_WDT_RESET,
    input wire logic        O_WATCHDOG_INTERVAL_IRQ,
    input wire logic        O_WATCHDOG_RESET_FLAG
);
    logic hit;
    assign hit = (I_ADDR == `PLW_SERVICE_KEY_ADDR);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);

    bad_key_a: assert property (I_WR && hit && !I_BIT_ACCESS && I_WDATA != `PLW_SERVICE_KEY_VALUE |=> O_WDT_RESET)
        else $error("wrong key gave no reset");
    bit_access_a: assert property ((I_WR || I_RD) && hit && I_BIT_ACCESS |=> O_WDT_RESET)
        else $error("bit access gave no reset");
    read_value_a: assert property (I_RD && hit && !I_BIT_ACCESS |=> O_RDATA inside {`PLW_SERVICE_RST_OFF, `PLW_SERVICE_RST_ON})
        else $error("service read not a reset value");
    read_other_a: assert property (I_RD && !hit |=> O_RDATA == 8'h00)
        else $error("unmapped read not zero");
    flag_set_a: assert property (O_WDT_RESET |=> O_WATCHDOG_RESET_FLAG)
        else $error("reset flag not set");
    flag_hold_a: assert property (O_WATCHDOG_RESET_FLAG |=> O_WATCHDOG_RESET_FLAG)
        else $error("reset flag dropped");
    reset_pulse_a: assert property (O_WDT_RESET |=> !O_WDT_RESET)
        else $error("internal reset longer than one cycle");
    irq_pulse_a: assert property ($rose(O_WATCHDOG_INTERVAL_IRQ) |=> !O_WATCHDOG_INTERVAL_IRQ)
        else $error("interval request longer than one cycle");
    // Sync delay is a few cycles, so eight quiet samples rule out a fresh tick
    slow_only_a: assert property (!I_SLOW_CLK [*8] |-> !O_WATCHDOG_INTERVAL_IRQ)
        else $error("interval request without slow clock edge");
endmodule

bind plw_watchdog plw_watchdog_props plw_watchdog_props_i (.I_CLK, .I_RST_B, .I_SLOW_CLK, .I_ADDR, .I_WR, .I_RD,
    .I_BIT_ACCESS, .I_WDATA, .O_RDATA, .O_WDT_RESET, .O_WATCHDOG_INTERVAL_IRQ, .O_WATCHDOG_RESET_FLAG);

/* program_loop_watchdog_bench.sv */
// Self-checking bench for the program loop watchdog
`timescale 1ns/1ps
`include "plw_defs.svh"

module program_loop_watchdog_bench;
    logic I_CLK = 0, I_RST_B = 0, I_SLOW_CLK = 0, I_STANDBY = 0;
    logic I_WR = 0, I_RD = 0, I_BIT_ACCESS = 0;
    logic [7:0] I_OPTION_BYTE = 8'h00, I_WDATA = 8'h00, O_RDATA;
    logic [19:0] I_ADDR = 20'h00000;
    logic O_WDT_RESET, O_WATCHDOG_INTERVAL_IRQ, O_WATCHDOG_RESET_FLAG;
    int bad_count = 0, compares = 0, irq_n = 0, rst_n = 0, n;
    int exps[6] = '{6, 7, 8, 9, 11, 13};

    plw_watchdog plw_watchdog_i (.I_CLK, .I_RST_B, .I_SLOW_CLK, .I_OPTION_BYTE, .I_STANDBY, .I_ADDR, .I_WR,
        .I_RD, .I_BIT_ACCESS, .I_WDATA, .O_RDATA, .O_WDT_RESET, .O_WATCHDOG_INTERVAL_IRQ, .O_WATCHDOG_RESET_FLAG);

    always #10 I_CLK = ~I_CLK;
    always @(posedge I_CLK) begin
        if (O_WATCHDOG_INTERVAL_IRQ === 1'b1) irq_n++;
        if (O_WDT_RESET === 1'b1) rst_n++;
    end

    // ********************************************************
    // Helpers
    // ********************************************************
    task cyc(input int k);
        repeat (k) @(posedge I_CLK);
        #1;
    endtask
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Long low phase lets the synchronised response land before checking
    task tick(input int k);
        repeat (k) begin
            I_SLOW_CLK = 1;
            cyc(2);
            I_SLOW_CLK = 0;
            cyc(4);
        end
    endtask
    task ev(input int ei, input int er);
        chk("irq count", 16'(irq_n), 16'(ei));
        chk("reset count", 16'(rst_n), 16'(er));
        irq_n = 0;
        rst_n = 0;
    endtask
    task acc(input logic [19:0] a, input logic w, input logic b, input logic [7:0] d);
        I_ADDR = a;
        I_WR = w;
        I_RD = !w;
        I_BIT_ACCESS = b;
        I_WDATA = d;
        cyc(1);
        {I_WR, I_RD, I_BIT_ACCESS} = 3'b000;
    endtask
    task do_reset(input logic [7:0] opt);
        I_RST_B = 0;
        I_OPTION_BYTE = opt;
        cyc(3);
        I_RST_B = 1;
        cyc(2);
        chk("flag", 16'(O_WATCHDOG_RESET_FLAG), 16'h0000);
        irq_n = 0;
        rst_n = 0;
    endtask
    task wrap_up;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #1800us;
        bad_count++;
        wrap_up;
    end

    // ********************************************************
    // Tests
    // ********************************************************
    initial begin
        for (int s = 0; s < 6; s++) begin
            n = 1 << exps[s];
            do_reset({3'b000, 1'b1, 3'(s), 1'b0});
            acc(`PLW_SERVICE_KEY_ADDR, 0, 0, 8'h00);
            chk("read", 16'(O_RDATA), 16'(`PLW_SERVICE_RST_ON));
            tick(n * 3 / 4 - 1);
            ev(0, 0);
            tick(1);
            ev(1, 0);
            tick(n / 4 - 1);
            ev(0, 0);
            tick(1);
            ev(0, 1);
            chk("flag", 16'(O_WATCHDOG_RESET_FLAG), 16'h0001);
        end
        $display("period test done");
        do_reset(8'h10);
        tick(40);
        acc(`PLW_SERVICE_KEY_ADDR, 1, 0, `PLW_SERVICE_KEY_VALUE);
        tick(47);
        ev(0, 0);
        tick(1);
        ev(1, 0);
        $display("key test done");
        acc(`PLW_SERVICE_KEY_ADDR, 1, 0, 8'h55);
        cyc(1);
        ev(0, 1);
        chk("flag", 16'(O_WATCHDOG_RESET_FLAG), 16'h0001);
        acc(`PLW_SERVICE_KEY_ADDR, 1, 1, `PLW_SERVICE_KEY_VALUE);
        cyc(1);
        ev(0, 1);
        acc(`PLW_SERVICE_KEY_ADDR, 0, 1, 8'h00);
        cyc(1);
        ev(0, 1);
        acc(20'hFFFAC, 0, 0, 8'h00);
        chk("unmapped read", 16'(O_RDATA), 16'h0000);
        cyc(1);
        acc(20'hFFFAA, 1, 0, 8'h55);
        cyc(1);
        ev(0, 0);
        $display("fault test done");
        do_reset(8'h00);
        acc(`PLW_SERVICE_KEY_ADDR, 0, 0, 8'h00);
        chk("read", 16'(O_RDATA), 16'(`PLW_SERVICE_RST_OFF));
        tick(70);
        ev(0, 0);
        $display("disabled test done");
        do_reset(8'h10);
        tick(40);
        I_STANDBY = 1;
        tick(40);
        ev(0, 0);
        I_STANDBY = 0;
        tick(47);
        ev(0, 0);
        tick(1);
        ev(1, 0);
        do_reset(8'h11);
        tick(40);
        I_STANDBY = 1;
        tick(8);
        ev(1, 0);
        I_STANDBY = 0;
        $display("standby test done");
        wrap_up;
    end
endmodule
